/* File: hdl/timer01_consts.vh */
`ifndef TIMER01_CONSTS_VH
`define TIMER01_CONSTS_VH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ADDR_CONTROL 8'h88
`define ADDR_MODE 8'h89
`define ADDR_ZERO_LOW 8'h8A
`define ADDR_ONE_LOW 8'h8B
`define ADDR_ZERO_HIGH 8'h8C
`define ADDR_ONE_HIGH 8'h8D
`define ADDR_RATE 8'h8E
// ----------------------------------------
// Control register bits
// ----------------------------------------
`define CTL_TF1 7
`define CTL_TR1 6
`define CTL_TF0 5
`define CTL_TR0 4
`define CTL_IE1 3
`define CTL_IT1 2
`define CTL_IE0 1
`define CTL_IT0 0
// ----------------------------------------
// Mode register fields, per-timer nibble; rate register bits
// ----------------------------------------
`define MODE_GATE 3
`define MODE_CT 2
`define MODE_M1 1
`define MODE_M0 0
`define RATE_ONE_BIT 4
`define RATE_ZERO_BIT 3
// ----------------------------------------
// Mode encodings, reset value and prescaler divides
// ----------------------------------------
`define MODE_13BIT 2'h0
`define MODE_16BIT 2'h1
`define MODE_RELOAD 2'h2
`define MODE_SPLIT 2'h3
`define RST_BYTE 8'h00
`define SLOW_DIV 12
`define FAST_DIV 4
`endif

/* File: hdl/pin_sync_edge.v */
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser with falling-edge pulse
module pin_sync_edge #(
    parameter WIDTH = 4
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire [WIDTH-1:0] i_pin,
    output wire [WIDTH-1:0] o_level,
    output wire [WIDTH-1:0] o_fall
);
    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;
    reg [WIDTH-1:0] prev_r;
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r <= {WIDTH{1'b1}};
            sync_r <= {WIDTH{1'b1}};
            prev_r <= {WIDTH{1'b1}};
        end else begin
            meta_r <= i_pin;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end
    assign o_level = sync_r;
    assign o_fall = prev_r & ~sync_r; // [RQ22]
endmodule
`default_nettype wire

/* File: hdl/timer01_ctrl.v */
// Functional notes
// [RQ1] Timers zero/one: clock timer or pin counter
// [RQ2] Sixteen-bit count as low/high byte registers
// [RQ3] Mode field: 13-bit, 16-bit, reload, split
// [RQ4] Timer one gate uses external irq pin
// [RQ5] Timer zero gate uses peripheral irq input
// [RQ6] Timer one source: clk/4, clk/12 or pin
// [RQ7] Timer zero source: clk/4, clk/12 or pin
// [RQ8] Timer one overflow sets bit 7, vector clears
// [RQ9] Timer zero overflow sets bit 5, vector clears
// [RQ10] Bits 6 and 4 are run bits
// [RQ11] Edge mode: falling edge sets bit 3
// [RQ12] Level mode: bit 3 follows pin, read-only
// [RQ13] Bit 2 selects irq-one edge or level
// [RQ14] Edge mode: falling edge sets bit 1
// [RQ15] Level mode: bit 1 follows input, read-only
// [RQ16] Bit 0 selects peripheral edge or level
// [RQ17] Mode register: timer one high nibble
// [RQ18] 13-bit wrap sets flag, pulses output
// [RQ19] 16-bit mode wraps after FFFFh
// [RQ20] Reload mode reloads low from high byte
// [RQ21] Split mode: high byte uses timer-one controls
// [RQ22] Pins synchronised, falling edges single pulses
// [RQ23] Reset clears all control bits
`include "timer01_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module timer01_ctrl (
    // Clock and reset
    input wire I_CLK_SYS,
    input wire I_NRST,
    // Register port
    input wire [7:0] I_ADDR,
    input wire I_WR,
    input wire I_RD,
    input wire [7:0] I_WDATA,
    output reg [7:0] O_RDATA,
    // Interrupt vectoring acknowledges
    input wire I_ACK_TIMER_ZERO,
    input wire I_ACK_TIMER_ONE,
    input wire I_ACK_PERIPH,
    input wire I_ACK_EXT_ONE,
    // Pins
    input wire I_COUNT_INPUT_ZERO,
    input wire I_COUNT_INPUT_ONE,
    input wire I_EXTERNAL_IRQ_ONE_PIN_N,
    input wire I_PERIPH_IRQ_N,
    // Status outputs
    output reg O_TIMER_ZERO_PULSE_OUT,
    output reg O_TIMER_ONE_PULSE_OUT,
    output reg O_TIMER_ZERO_OVERFLOW_FLAG,
    output reg O_TIMER_ONE_OVERFLOW_FLAG,
    output reg O_PERIPH_IRQ_DETECT,
    output reg O_EXT_IRQ_ONE_DETECT
);
    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    reg rst_meta_r;
    reg rst_n_r;
    always @(posedge I_CLK_SYS or negedge I_NRST) begin
        if (!I_NRST) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    wire [3:0] pin_level;
    wire [3:0] pin_fall;
    pin_sync_edge #(.WIDTH(4)) u_sync (
        .i_clk(I_CLK_SYS),
        .i_rst_n(rst_n_r),
        .i_pin({I_PERIPH_IRQ_N, I_EXTERNAL_IRQ_ONE_PIN_N, I_COUNT_INPUT_ONE,
                I_COUNT_INPUT_ZERO}), // [RQ22]
        .o_level(pin_level),
        .o_fall(pin_fall)
    );
    wire t0_pin_fall = pin_fall[0];
    wire t1_pin_fall = pin_fall[1];
    wire ext1_level = pin_level[2];
    wire ext1_fall = pin_fall[2];
    wire periph_level = pin_level[3];
    wire periph_fall = pin_fall[3];

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [7:0] mode_r;
    reg [7:0] rate_r;
    reg tr1_r, tr0_r, it1_r, it0_r;
    reg tf1_r, tf0_r, ie1_edge_r, ie0_edge_r;
    reg [15:0] t0_r, t1_r;
    reg [3:0] div12_r;
    reg [1:0] div4_r;
    reg tick4_r, tick12_r;

    wire wr_ctl = I_WR && (I_ADDR == `ADDR_CONTROL);
    wire wr_mode = I_WR && (I_ADDR == `ADDR_MODE);
    wire [1:0] t0_mode = {mode_r[`MODE_M1], mode_r[`MODE_M0]}; // [RQ3] [RQ17]
    wire [1:0] t1_mode = {mode_r[4 + `MODE_M1], mode_r[4 + `MODE_M0]}; // [RQ17]
    wire t0_gate = mode_r[`MODE_GATE];
    wire t1_gate = mode_r[4 + `MODE_GATE];
    wire t0_ct = mode_r[`MODE_CT];
    wire t1_ct = mode_r[4 + `MODE_CT];

    // ----------------------------------------
    // Prescaler enables
    // ----------------------------------------
    // Free running, so a rate change takes at most one period to apply
    // Compared at integer width so the divide counts need no cast
    wire div12_last = ({28'h0000000, div12_r} == `SLOW_DIV - 1);
    wire div4_last = ({30'h00000000, div4_r} == `FAST_DIV - 1);
    always @(posedge I_CLK_SYS or negedge rst_n_r) begin
        if (!rst_n_r) begin
            div12_r <= 4'h0;
            div4_r <= 2'h0;
            tick4_r <= 1'b0;
            tick12_r <= 1'b0;
        end else begin
            div12_r <= div12_last ? 4'h0 : div12_r + 4'h1;
            div4_r <= div4_last ? 2'h0 : div4_r + 2'h1;
            tick12_r <= div12_last;
            tick4_r <= div4_last;
        end
    end
    wire t0_clk_tick = rate_r[`RATE_ZERO_BIT] ? tick4_r : tick12_r;
    wire t1_clk_tick = rate_r[`RATE_ONE_BIT] ? tick4_r : tick12_r;

    // Step sources and gating
    wire t0_step_src = t0_ct ? t0_pin_fall : t0_clk_tick; // [RQ7] [RQ1]
    wire t1_step_src = t1_ct ? t1_pin_fall : t1_clk_tick; // [RQ6] [RQ1]
    wire t0_en = tr0_r && (!t0_gate || periph_level); // [RQ5]
    wire t1_en = tr1_r && (!t1_gate || ext1_level); // [RQ4]
    wire t0_step = t0_en && t0_step_src;
    wire t1_step = (t1_mode != `MODE_SPLIT) && t1_en && t1_step_src; // [RQ21]
    // Split-mode high byte of timer zero: clock only, timer-one run bit
    wire t0h_step = (t0_mode == `MODE_SPLIT) && tr1_r && t0_clk_tick; // [RQ21]

    // ----------------------------------------
    // Counter next-state
    // ----------------------------------------
    function [16:0] next_count;
        input [1:0] mode;
        input [15:0] cnt;
        reg [12:0] c13;
        reg [16:0] c16;
        reg [8:0] c8;
        begin
            c13 = {cnt[15:8], cnt[4:0]} + 13'h0001;
            c16 = {1'b0, cnt} + 17'h00001;
            c8 = {1'b0, cnt[7:0]} + 9'h001;
            case (mode)
                `MODE_13BIT: begin
                    // Top bits of low byte are kept, software masks them
                    next_count = {(c13 == 13'h0000), c13[12:5], cnt[7:5], c13[4:0]}; // [RQ18]
                end
                `MODE_16BIT: begin
                    next_count = c16; // [RQ19]
                end
                `MODE_RELOAD: begin
                    next_count = {c8[8], cnt[15:8], c8[8] ? cnt[15:8] : c8[7:0]}; // [RQ20]
                end
                default: begin
                    next_count = {c8[8], cnt[15:8], c8[7:0]};
                end
            endcase
        end
    endfunction

    wire [16:0] t0_nxt = next_count(t0_mode, t0_r);
    wire [16:0] t1_nxt = next_count(t1_mode, t1_r);
    wire [8:0] t0h_inc = {1'b0, t0_r[15:8]} + 9'h001;
    wire t0_ovf = t0_step && t0_nxt[16];
    wire t1_ovf = t1_step && t1_nxt[16];
    wire t0h_ovf = t0h_step && t0h_inc[8];
    wire tf1_set = t1_ovf || t0h_ovf; // [RQ21]

    // ----------------------------------------
    // Count registers and byte access
    // ----------------------------------------
    always @(posedge I_CLK_SYS or negedge rst_n_r) begin
        if (!rst_n_r) begin
            t0_r <= {`RST_BYTE, `RST_BYTE};
            t1_r <= {`RST_BYTE, `RST_BYTE};
        end else begin
            if (I_WR && I_ADDR == `ADDR_ZERO_LOW) begin
                t0_r[7:0] <= I_WDATA; // [RQ2]
            end else if (t0_step) begin
                t0_r[7:0] <= t0_nxt[7:0];
            end
            if (I_WR && I_ADDR == `ADDR_ZERO_HIGH) begin
                t0_r[15:8] <= I_WDATA; // [RQ2]
            end else if (t0_mode == `MODE_SPLIT) begin
                if (t0h_step) begin
                    t0_r[15:8] <= t0h_inc[7:0];
                end
            end else if (t0_step) begin
                t0_r[15:8] <= t0_nxt[15:8];
            end
            if (I_WR && I_ADDR == `ADDR_ONE_LOW) begin
                t1_r[7:0] <= I_WDATA;
            end else if (t1_step) begin
                t1_r[7:0] <= t1_nxt[7:0];
            end
            if (I_WR && I_ADDR == `ADDR_ONE_HIGH) begin
                t1_r[15:8] <= I_WDATA;
            end else if (t1_step) begin
                t1_r[15:8] <= t1_nxt[15:8];
            end
        end
    end

    // ----------------------------------------
    // Control, mode and flags
    // ----------------------------------------
    always @(posedge I_CLK_SYS or negedge rst_n_r) begin
        if (!rst_n_r) begin
            mode_r <= `RST_BYTE; // [RQ23]
            rate_r <= `RST_BYTE;
            tr1_r <= 1'b0;
            tr0_r <= 1'b0;
            it1_r <= 1'b0;
            it0_r <= 1'b0;
            tf1_r <= 1'b0;
            tf0_r <= 1'b0;
            ie1_edge_r <= 1'b0;
            ie0_edge_r <= 1'b0;
        end else begin
            if (wr_mode) begin
                mode_r <= I_WDATA;
            end
            if (I_WR && I_ADDR == `ADDR_RATE) begin
                rate_r <= I_WDATA & 8'h18;
            end
            if (wr_ctl) begin
                tr1_r <= I_WDATA[`CTL_TR1]; // [RQ10]
                tr0_r <= I_WDATA[`CTL_TR0]; // [RQ10]
                it1_r <= I_WDATA[`CTL_IT1]; // [RQ13]
                it0_r <= I_WDATA[`CTL_IT0]; // [RQ16]
            end
            // Set wins over vector clear and software write
            if (tf1_set) begin
                tf1_r <= 1'b1; // [RQ8]
            end else if (I_ACK_TIMER_ONE) begin
                tf1_r <= 1'b0; // [RQ8]
            end else if (wr_ctl) begin
                tf1_r <= I_WDATA[`CTL_TF1];
            end
            if (t0_ovf) begin
                tf0_r <= 1'b1; // [RQ9]
            end else if (I_ACK_TIMER_ZERO) begin
                tf0_r <= 1'b0; // [RQ9]
            end else if (wr_ctl) begin
                tf0_r <= I_WDATA[`CTL_TF0];
            end
            if (!it1_r) begin
                ie1_edge_r <= 1'b0;
            end else if (ext1_fall) begin
                ie1_edge_r <= 1'b1; // [RQ11]
            end else if (I_ACK_EXT_ONE || (wr_ctl && !I_WDATA[`CTL_IE1])) begin
                ie1_edge_r <= 1'b0; // [RQ11]
            end
            if (!it0_r) begin
                ie0_edge_r <= 1'b0;
            end else if (periph_fall) begin
                ie0_edge_r <= 1'b1; // [RQ14]
            end else if (I_ACK_PERIPH || (wr_ctl && !I_WDATA[`CTL_IE0])) begin
                ie0_edge_r <= 1'b0; // [RQ14]
            end
        end
    end

    // Level mode flags follow the pins; writes do not reach them
    wire ie1_val = it1_r ? ie1_edge_r : !ext1_level; // [RQ12]
    wire ie0_val = it0_r ? ie0_edge_r : !periph_level; // [RQ15]

    // ----------------------------------------
    // Read data and outputs
    // ----------------------------------------
    reg [7:0] rdata_nxt;
    always @* begin
        case (I_ADDR)
            `ADDR_CONTROL: begin
                rdata_nxt = {tf1_r, tr1_r, tf0_r, tr0_r, ie1_val, it1_r, ie0_val, it0_r};
            end
            `ADDR_MODE: rdata_nxt = mode_r;
            `ADDR_ZERO_LOW: rdata_nxt = t0_r[7:0];
            `ADDR_ZERO_HIGH: rdata_nxt = t0_r[15:8];
            `ADDR_ONE_LOW: rdata_nxt = t1_r[7:0];
            `ADDR_ONE_HIGH: rdata_nxt = t1_r[15:8];
            `ADDR_RATE: rdata_nxt = rate_r;
            default: rdata_nxt = 8'h00;
        endcase
    end

    always @(posedge I_CLK_SYS or negedge rst_n_r) begin
        if (!rst_n_r) begin
            O_RDATA <= 8'h00;
            O_TIMER_ZERO_PULSE_OUT <= 1'b0;
            O_TIMER_ONE_PULSE_OUT <= 1'b0;
            O_TIMER_ZERO_OVERFLOW_FLAG <= 1'b0;
            O_TIMER_ONE_OVERFLOW_FLAG <= 1'b0;
            O_PERIPH_IRQ_DETECT <= 1'b0;
            O_EXT_IRQ_ONE_DETECT <= 1'b0;
        end else begin
            O_RDATA <= I_RD ? rdata_nxt : 8'h00;
            O_TIMER_ZERO_PULSE_OUT <= t0_ovf; // [RQ18]
            O_TIMER_ONE_PULSE_OUT <= tf1_set;
            O_TIMER_ZERO_OVERFLOW_FLAG <= tf0_r;
            O_TIMER_ONE_OVERFLOW_FLAG <= tf1_r;
            O_PERIPH_IRQ_DETECT <= ie0_val;
            O_EXT_IRQ_ONE_DETECT <= ie1_val;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/vector_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// CPU vectoring: one acknowledge per raised flag
// ----------------------------------------
module vector_model (
    // Clock and control
    input wire i_clk,
    input wire i_en,
    // Flags seen, acknowledges given
    input wire [3:0] i_flag,
    output reg [3:0] o_ack
);
    reg [3:0] seen_r = 4'h0;
    initial o_ack = 4'h0;
    // Acks only on a fresh flag, so a slow flag copy is not acked twice
    always @(negedge i_clk) begin
        o_ack <= i_en ? (i_flag & ~seen_r) : 4'h0;
        seen_r <= i_en ? i_flag : 4'h0;
    end
endmodule
`default_nettype wire

/* File: testbench/timer01_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module timer01_props (
    input wire I_CLK_SYS, input wire I_NRST, input wire [7:0] I_ADDR,
    input wire I_WR, input wire I_RD, input wire [7:0] O_RDATA,
    input wire I_ACK_TIMER_ZERO, input wire I_ACK_TIMER_ONE,
    input wire O_TIMER_ZERO_PULSE_OUT, input wire O_TIMER_ONE_PULSE_OUT,
    input wire O_TIMER_ZERO_OVERFLOW_FLAG, input wire O_TIMER_ONE_OVERFLOW_FLAG,
    input wire O_PERIPH_IRQ_DETECT, input wire O_EXT_IRQ_ONE_DETECT
);
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_NRST);
    zero_pulse_single_a: assert property (
        O_TIMER_ZERO_PULSE_OUT |=> !O_TIMER_ZERO_PULSE_OUT)
        else $error("zero pulse longer than one cycle");
    one_pulse_single_a: assert property (O_TIMER_ONE_PULSE_OUT |=> !O_TIMER_ONE_PULSE_OUT)
        else $error("one pulse longer than one cycle");
    // Pulse leaves with the inner flag set; the flag output follows one cycle later
    zero_pulse_flag_a: assert property (
        O_TIMER_ZERO_PULSE_OUT |=> O_TIMER_ZERO_OVERFLOW_FLAG)
        else $error("zero pulse without flag");
    one_pulse_flag_a: assert property (
        O_TIMER_ONE_PULSE_OUT |=> O_TIMER_ONE_OVERFLOW_FLAG)
        else $error("one pulse without flag");
    zero_flag_cause_a: assert property ($rose(O_TIMER_ZERO_OVERFLOW_FLAG) |->
        $past(O_TIMER_ZERO_PULSE_OUT) || ($past(I_WR, 2) && $past(I_ADDR, 2) == 8'h88))
        else $error("zero flag set without cause");
    one_flag_cause_a: assert property ($rose(O_TIMER_ONE_OVERFLOW_FLAG) |->
        $past(O_TIMER_ONE_PULSE_OUT) || ($past(I_WR, 2) && $past(I_ADDR, 2) == 8'h88))
        else $error("one flag set without cause");
    zero_flag_hold_a: assert property ($fell(O_TIMER_ZERO_OVERFLOW_FLAG) |->
        $past(I_ACK_TIMER_ZERO, 2) || $past(I_WR, 2)) else $error("zero flag lost");
    one_flag_hold_a: assert property ($fell(O_TIMER_ONE_OVERFLOW_FLAG) |->
        $past(I_ACK_TIMER_ONE, 2) || $past(I_WR, 2)) else $error("one flag lost");
    unmapped_read_zero_a: assert property (I_RD && (I_ADDR < 8'h88 || I_ADDR > 8'h8E)
        |=> O_RDATA == 8'h00) else $error("unmapped read not zero");
    detect_read_match_a: assert property (I_RD && I_ADDR == 8'h88 |=>
        O_RDATA[3] == O_EXT_IRQ_ONE_DETECT && O_RDATA[1] == O_PERIPH_IRQ_DETECT)
        else $error("detect bits differ from outputs");
endmodule
`default_nettype wire

/* File: testbench/timer01_ctrl_bench.sv */
`include "timer01_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module timer01_ctrl_bench;
    reg clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, en = 1'b0;
    reg cnt0 = 1'b1, cnt1 = 1'b1, pin1 = 1'b1, pinp = 1'b1;
    reg [7:0] addr = 8'h00, wdata = 8'h00, v, w, t, d;
    wire [7:0] rdata;
    wire [3:0] ack;
    wire p0, p1, f0, f1, dp, d1;
    wire [5:0] outs = {d1, dp, f1, f0, p1, p0};
    integer fails = 0, comparisons = 0, i, n;
    always #4 clk = ~clk;
    timer01_ctrl DUT (
        .I_CLK_SYS(clk), .I_NRST(nrst), .I_ADDR(addr), .I_WR(wr), .I_RD(rd),
        .I_WDATA(wdata), .O_RDATA(rdata), .I_ACK_TIMER_ZERO(ack[0]),
        .I_ACK_TIMER_ONE(ack[1]), .I_ACK_PERIPH(ack[2]), .I_ACK_EXT_ONE(ack[3]),
        .I_COUNT_INPUT_ZERO(cnt0), .I_COUNT_INPUT_ONE(cnt1),
        .I_EXTERNAL_IRQ_ONE_PIN_N(pin1), .I_PERIPH_IRQ_N(pinp),
        .O_TIMER_ZERO_PULSE_OUT(p0), .O_TIMER_ONE_PULSE_OUT(p1),
        .O_TIMER_ZERO_OVERFLOW_FLAG(f0), .O_TIMER_ONE_OVERFLOW_FLAG(f1),
        .O_PERIPH_IRQ_DETECT(dp), .O_EXT_IRQ_ONE_DETECT(d1));
    vector_model u_cpu (.i_clk(clk), .i_en(en), .i_flag({d1, dp, f1, f0}), .o_ack(ack));
    // ----------------------------------------
    // Register access and checking
    // ----------------------------------------
    task report_and_stop;
        begin
            $display("comparisons %0d fails %0d", comparisons, fails);
            if (fails == 0 && comparisons > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    task check(input [8*12-1:0] name, input [7:0] seen, input [7:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("[FAIL] %0s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    task wreg(input [7:0] a, input [7:0] x);
        begin
            @(negedge clk);
            addr = a;
            wdata = x;
            wr = 1'b1;
            @(negedge clk);
            wr = 1'b0;
        end
    endtask
    task rreg(input [7:0] a);
        begin
            @(negedge clk);
            addr = a;
            rd = 1'b1;
            @(negedge clk);
            rd = 1'b0;
            v = rdata;
        end
    endtask
    // Bounded wait on a one-cycle status pulse
    task waitbit(input integer b);
        begin
            n = 0;
            while (outs[b] !== 1'b1 && n < 60) begin
                @(negedge clk);
                n = n + 1;
            end
            if (n >= 60) begin
                fails = fails + 1;
                $display("[FAIL] pulse wait expected 1 seen 0");
                report_and_stop;
            end
        end
    endtask
    task setpin(input integer s, input x);
        if (s == 1) pin1 = x;
        else pinp = x;
    endtask
    // Window of exactly 120 clocks between the two samples
    task rate(input [7:0] r, input p, input [7:0] c, input [7:0] e);
        begin
            wreg(`ADDR_RATE, r);
            pin1 = p;
            wreg(`ADDR_CONTROL, c);
            rreg(`ADDR_ONE_LOW);
            w = v;
            repeat (118) @(negedge clk);
            rreg(`ADDR_ONE_LOW);
            check("rate", v - w, e);
        end
    endtask
    task ovf(input [7:0] m, a1, x1, a2, x2, c, input integer b, input [7:0] ca, mk, ex, fm);
        begin
            wreg(`ADDR_CONTROL, 8'h00);
            wreg(`ADDR_MODE, m);
            wreg(a1, x1);
            wreg(a2, x2);
            en = 1'b1;
            wreg(`ADDR_CONTROL, c);
            waitbit(b);
            rreg(ca);
            check("count", v & mk, ex);
            repeat (8) @(negedge clk);
            rreg(`ADDR_CONTROL);
            check("vector", v & fm, 8'h00);
            en = 1'b0;
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        rreg(`ADDR_CONTROL);
        check("control", v, `RST_BYTE);
        rreg(`ADDR_MODE);
        check("mode", v, `RST_BYTE);
        rreg(8'h90);
        check("unmapped", v, 8'h00);
        wreg(`ADDR_MODE, 8'hA5);
        rreg(`ADDR_MODE);
        check("mode rw", v, 8'hA5);
        wreg(`ADDR_MODE, 8'h90);
        rate(8'h00, 1'b1, 8'h40, 8'd10);
        rate(8'h10, 1'b1, 8'h40, 8'd30);
        rate(8'h10, 1'b0, 8'h40, 8'd0);
        rate(8'h10, 1'b1, 8'h00, 8'd0);
        wreg(`ADDR_RATE, 8'h18);
        ovf(8'h01, `ADDR_ZERO_LOW, 8'hFE, `ADDR_ZERO_HIGH, 8'hFF, 8'h10, 0,
            `ADDR_ZERO_HIGH, 8'hFF, 8'h00, 8'h20);
        ovf(8'h00, `ADDR_ONE_LOW, 8'h1F, `ADDR_ONE_HIGH, 8'hFF, 8'h40, 1,
            `ADDR_ONE_HIGH, 8'hFF, 8'h00, 8'h80);
        ovf(8'h02, `ADDR_ZERO_HIGH, 8'h80, `ADDR_ZERO_LOW, 8'hFF, 8'h10, 0,
            `ADDR_ZERO_LOW, 8'hF0, 8'h80, 8'h20);
        ovf(8'h03, `ADDR_ZERO_LOW, 8'h00, `ADDR_ZERO_HIGH, 8'hFF, 8'h40, 1,
            `ADDR_ZERO_LOW, 8'hFF, 8'h00, 8'h80);
        // Pin counting; timer zero's first fall is gated off by the low peripheral input, timer one counts all three
        wreg(`ADDR_CONTROL, 8'h00);
        wreg(`ADDR_MODE, 8'h5D);
        wreg(`ADDR_ZERO_LOW, 8'hFE);
        wreg(`ADDR_ZERO_HIGH, 8'hFF);
        wreg(`ADDR_ONE_LOW, 8'h00);
        wreg(`ADDR_CONTROL, 8'h50);
        for (i = 0; i < 3; i = i + 1) begin
            pinp = (i != 0);
            repeat (4) @(negedge clk);
            cnt0 = 1'b0;
            cnt1 = 1'b0;
            repeat (4) @(negedge clk);
            cnt0 = 1'b1;
            cnt1 = 1'b1;
        end
        rreg(`ADDR_ZERO_LOW);
        check("pin count", v, 8'h00);
        rreg(`ADDR_ONE_LOW);
        check("pin one", v, 8'h03);
        rreg(`ADDR_CONTROL);
        check("pin ovf", v & 8'h20, 8'h20);
        for (i = 0; i < 2; i = i + 1) begin
            t = 8'h01 << (2 * i);
            d = 8'h02 << (2 * i);
            wreg(`ADDR_CONTROL, 8'h00);
            setpin(i, 1'b0);
            repeat (6) @(negedge clk);
            rreg(`ADDR_CONTROL);
            check("level low", v & d, d);
            setpin(i, 1'b1);
            wreg(`ADDR_CONTROL, d);
            repeat (6) @(negedge clk);
            rreg(`ADDR_CONTROL);
            check("level high", v & d, 8'h00);
            wreg(`ADDR_CONTROL, t);
            setpin(i, 1'b0);
            repeat (6) @(negedge clk);
            check("edge set", {7'h00, outs[4 + i]}, 8'h01);
            wreg(`ADDR_CONTROL, t);
            repeat (4) @(negedge clk);
            check("edge clear", {7'h00, outs[4 + i]}, 8'h00);
            setpin(i, 1'b1);
            en = 1'b1;
            repeat (4) @(negedge clk);
            setpin(i, 1'b0);
            repeat (10) @(negedge clk);
            check("edge vector", {7'h00, outs[4 + i]}, 8'h00);
            en = 1'b0;
            setpin(i, 1'b1);
        end
        report_and_stop;
    end
endmodule
bind timer01_ctrl timer01_props u_props (
    .I_CLK_SYS(I_CLK_SYS),
    .I_NRST(I_NRST),
    .I_ADDR(I_ADDR),
    .I_WR(I_WR),
    .I_RD(I_RD),
    .O_RDATA(O_RDATA),
    .I_ACK_TIMER_ZERO(I_ACK_TIMER_ZERO),
    .I_ACK_TIMER_ONE(I_ACK_TIMER_ONE),
    .O_TIMER_ZERO_PULSE_OUT(O_TIMER_ZERO_PULSE_OUT),
    .O_TIMER_ONE_PULSE_OUT(O_TIMER_ONE_PULSE_OUT),
    .O_TIMER_ZERO_OVERFLOW_FLAG(O_TIMER_ZERO_OVERFLOW_FLAG),
    .O_TIMER_ONE_OVERFLOW_FLAG(O_TIMER_ONE_OVERFLOW_FLAG),
    .O_PERIPH_IRQ_DETECT(O_PERIPH_IRQ_DETECT),
    .O_EXT_IRQ_ONE_DETECT(O_EXT_IRQ_ONE_DETECT)
);
`default_nettype wire
